// [hw/buck_ctrl.v]
/*
  Digital control core of a step-down regulator: enable logic, voltage
  select, mode, soft-start, upward slew limiting, downward coast and
  current-limit retry, with a small register bank.
  Assumes analog comparators and pins arrive asynchronous to CLK_I and
  a register master on CLK_I using one-cycle strobes.
*/
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "buck_ctrl_defs.vh"

module buck_ctrl #(
  parameter [7:0] LOW_SEL_RESET = `LOW_SEL_RESET,
  parameter [7:0] HIGH_SEL_RESET = `HIGH_SEL_RESET,
  parameter integer RETRY_CYCLES = `RETRY_CYCLES,
  parameter integer SS_STEP_CYCLES = `SS_STEP_CYCLES,
  parameter integer CL_RUN_LIMIT = `CL_RUN_LIMIT
) (
  input wire CLK_I,
  input wire RESET_I,
  input wire HW_ENABLE_I,
  input wire VOLTAGE_SELECT_PIN_I,
  input wire CUR_LIMIT_I,
  input wire LIGHT_LOAD_I,
  input wire OUT_SETTLED_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  output reg [5:0] REF_CODE_O,
  output reg SWITCH_EN_O,
  output reg SYNC_RECT_EN_O,
  output reg TRISTATE_O,
  output reg DISCHARGE_O,
  output reg FORCE_PWM_O,
  output reg PFM_O,
  output reg SW_TICK_O
);

  // One-hot states
  localparam [4:0] ST_OFF = 5'h01;
  localparam [4:0] ST_SOFT = 5'h02;
  localparam [4:0] ST_RUN = 5'h04;
  localparam [4:0] ST_FALL = 5'h08;
  localparam [4:0] ST_FAULT = 5'h10;
  localparam integer SYNC_N = 5;
  // Divider reload; the tick cycle itself counts as one of the period
  localparam integer SW_DIV_M1 = `SW_DIV_CYCLES - 1;

  // Interval for one upward code step, rounded up so the rate is never exceeded
  function [16:0] slew_cycles;
    input [2:0] code;
    reg [31:0] ps;
    reg [31:0] cyc;
    begin
      ps = `SLEW_STEP_PS << code;
      cyc = (ps + `CLK_PS - 1) / `CLK_PS;
      // Longest interval is 1000 cycles, well inside 17 bits
      slew_cycles = cyc[16:0];
    end
  endfunction

  // Two-flop synchronisers for every pin and comparator, one per bit
  wire [SYNC_N-1:0] raw_in = {OUT_SETTLED_I, LIGHT_LOAD_I, CUR_LIMIT_I,
                              VOLTAGE_SELECT_PIN_I, HW_ENABLE_I};
  reg [SYNC_N-1:0] meta_ff;
  reg [SYNC_N-1:0] sync_ff;
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
      always @(posedge CLK_I) begin
        if (RESET_I) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= raw_in[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
  wire en_pin = sync_ff[0];
  wire sel_pin = sync_ff[1];
  wire cl_pin = sync_ff[2];
  wire light_pin = sync_ff[3];
  wire settled_pin = sync_ff[4];

  // Register bank
  reg [7:0] low_select_voltage_reg_ff;
  reg [7:0] high_select_voltage_reg_ff;
  reg [7:0] control_ff;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [5:0] ref_ff;
  reg [5:0] nxt_ref;
  reg [16:0] timer_ff;
  reg [16:0] nxt_timer;
  reg [4:0] cl_cnt_ff;
  reg [4:0] nxt_cl_cnt;
  reg cl_seen_ff;
  reg [4:0] div_ff;

  // Registers sit at defaults whenever the pin is low; access is dead then
  always @(posedge CLK_I) begin
    if (RESET_I || !en_pin) begin
      low_select_voltage_reg_ff <= LOW_SEL_RESET;
      high_select_voltage_reg_ff <= HIGH_SEL_RESET;
      control_ff <= `CONTROL_RESET;
    end else if (WR_I) begin
      case (ADDR_I)
        `ADDR_LOW_SEL: low_select_voltage_reg_ff <= WDATA_I;
        `ADDR_HIGH_SEL: high_select_voltage_reg_ff <= WDATA_I;
        `ADDR_CONTROL: control_ff <= WDATA_I;
        default: ;
      endcase
    end
  end

  // Read data in the cycle after the strobe; unmapped and idle reads give zero
  always @(posedge CLK_I) begin
    if (RESET_I || !en_pin || !RD_I) begin
      RDATA_O <= 8'h00;
    end else begin
      case (ADDR_I)
        `ADDR_LOW_SEL: RDATA_O <= low_select_voltage_reg_ff;
        `ADDR_HIGH_SEL: RDATA_O <= high_select_voltage_reg_ff;
        `ADDR_CONTROL: RDATA_O <= control_ff;
        `ADDR_MONITOR: RDATA_O <= {state_ff, 1'b0, cl_seen_ff, SWITCH_EN_O};
        default: RDATA_O <= 8'h00;
      endcase
    end
  end

  // Selected register follows the pin every cycle
  wire [7:0] sel_reg = sel_pin ? high_select_voltage_reg_ff
                               : low_select_voltage_reg_ff;
  wire sw_enable_selected = sel_reg[`VREG_EN_BIT];
  wire mode_pwm = sel_reg[`VREG_MODE_BIT];
  // Reference code: 0 means 0.60 V, each count 12.5 mV above it
  wire [5:0] voltage_code = sel_reg[`VREG_CODE_MSB:`VREG_CODE_LSB];
  wire run_req = en_pin && sw_enable_selected;
  wire [2:0] slew_code = control_ff[`CTRL_SLEW_MSB:`CTRL_SLEW_LSB];
  // Slew and soft-start timer reloads are one short: the step lands on the cycle the timer hits zero
  wire [16:0] slew_len = slew_cycles(slew_code) - 17'h00001;
  wire [16:0] retry_len = RETRY_CYCLES[16:0];
  wire [16:0] ss_len = SS_STEP_CYCLES[16:0] - 17'h00001;
  wire [4:0] cl_last = CL_RUN_LIMIT[4:0] - 5'h01;

  // Switching-cycle divider; one tick per nominal cycle
  wire sw_tick = (div_ff == 5'h00);
  always @(posedge CLK_I) begin
    if (RESET_I || !en_pin) begin
      div_ff <= 5'h00;
    end else if (sw_tick) begin
      div_ff <= SW_DIV_M1[4:0];
    end else begin
      div_ff <= div_ff - 5'h01;
    end
  end

  // Current limit seen within this switching cycle; a hit on the tick counts
  always @(posedge CLK_I) begin
    if (RESET_I || !en_pin) begin
      cl_seen_ff <= 1'b0;
    end else if (cl_pin) begin
      cl_seen_ff <= 1'b1; // Set wins over the tick clear
    end else if (sw_tick) begin
      cl_seen_ff <= 1'b0;
    end
  end

  wire cl_cycle = cl_seen_ff || cl_pin;
  wire switching = state_ff[1] || state_ff[2];

  // Sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_ref = ref_ff;
    nxt_timer = (timer_ff == 17'h00000) ? 17'h00000 : timer_ff - 17'h00001;
    nxt_cl_cnt = cl_cnt_ff;
    if (switching && sw_tick) begin
      nxt_cl_cnt = cl_cycle ? cl_cnt_ff + 5'h01 : 5'h00;
    end
    case (state_ff)
      ST_OFF: begin
        nxt_ref = 6'h00;
        nxt_cl_cnt = 5'h00;
        if (run_req) begin
          nxt_state = ST_SOFT;
          nxt_timer = ss_len;
        end
      end
      ST_SOFT: begin
        // Slow reference ramp keeps inrush and overshoot down
        if (ref_ff >= voltage_code) begin
          nxt_ref = voltage_code;
          nxt_state = ST_RUN;
        end else if (timer_ff == 17'h00000) begin
          nxt_ref = ref_ff + 6'h01;
          nxt_timer = ss_len;
        end
      end
      ST_RUN: begin
        if (voltage_code < ref_ff) begin
          nxt_ref = voltage_code;
          nxt_state = ST_FALL;
        end else if (voltage_code > ref_ff && timer_ff == 17'h00000) begin
          nxt_ref = ref_ff + 6'h01;
          nxt_timer = slew_len;
        end
      end
      ST_FALL: begin
        // Load alone pulls the output down; no negative current drawn
        if (voltage_code < ref_ff) begin
          nxt_ref = voltage_code;
        end
        if (settled_pin) begin
          nxt_state = ST_RUN;
          nxt_timer = slew_len;
        end
      end
      ST_FAULT: begin
        nxt_ref = 6'h00;
        nxt_cl_cnt = 5'h00;
        if (timer_ff == 17'h00000) begin
          nxt_state = ST_SOFT;
          nxt_timer = ss_len;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
    // Overload check only while switching
    if (switching && sw_tick && cl_cycle && cl_cnt_ff == cl_last) begin
      nxt_state = ST_FAULT;
      nxt_timer = retry_len;
      nxt_ref = 6'h00;
      nxt_cl_cnt = 5'h00;
    end
    if (!run_req) begin
      nxt_state = ST_OFF;
      nxt_ref = 6'h00;
      nxt_cl_cnt = 5'h00;
    end
  end

  always @(posedge CLK_I) begin
    if (RESET_I || !en_pin) begin
      state_ff <= ST_OFF;
      ref_ff <= 6'h00;
      timer_ff <= 17'h00000;
      cl_cnt_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      ref_ff <= nxt_ref;
      timer_ff <= nxt_timer;
      cl_cnt_ff <= nxt_cl_cnt;
    end
  end

  // Output flops; all switching quiet while the pin is low
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      REF_CODE_O <= 6'h00;
      SWITCH_EN_O <= 1'b0;
      SYNC_RECT_EN_O <= 1'b0;
      TRISTATE_O <= 1'b1;
      DISCHARGE_O <= 1'b0;
      FORCE_PWM_O <= 1'b0;
      PFM_O <= 1'b0;
      SW_TICK_O <= 1'b0;
    end else begin
      REF_CODE_O <= ref_ff;
      SWITCH_EN_O <= en_pin && switching;
      SYNC_RECT_EN_O <= en_pin && state_ff[2];
      TRISTATE_O <= !(en_pin && switching);
      // Bleed uses the reset-value bit when the pin is low
      DISCHARGE_O <= control_ff[`CTRL_DISCH_BIT] &&
                     (!en_pin || !sw_enable_selected);
      FORCE_PWM_O <= en_pin && mode_pwm;
      PFM_O <= en_pin && state_ff[2] && !mode_pwm && light_pin;
      SW_TICK_O <= en_pin && switching && sw_tick;
    end
  end

endmodule

// [hw/buck_ctrl_defs.vh]
/*
  Constants for the step-down regulator control core: register offsets,
  field positions, reset values and timing figures.
  Assumes a 50 MHz core clock; included by the core by its bare name.
*/
`ifndef BUCK_CTRL_DEFS_VH
`define BUCK_CTRL_DEFS_VH

// Register offsets (8-bit address space)
`define ADDR_LOW_SEL 8'h00
`define ADDR_HIGH_SEL 8'h01
`define ADDR_CONTROL 8'h02
`define ADDR_MONITOR 8'h05

// Voltage register fields
`define VREG_EN_BIT 7
`define VREG_MODE_BIT 6
`define VREG_CODE_MSB 5
`define VREG_CODE_LSB 0

// Control register fields
`define CTRL_DISCH_BIT 7
`define CTRL_SLEW_MSB 2
`define CTRL_SLEW_LSB 0

// Reset values
`define LOW_SEL_RESET 8'h00
`define HIGH_SEL_RESET 8'hA0
`define CONTROL_RESET 8'h80

// Clock figures
`define CLK_PS 20000
`define CLK_KHZ 50000

// Nominal switching rate, rounded to nearest whole divider
`define SW_FREQ_KHZ 2400
`define SW_DIV_CYCLES ((`CLK_KHZ + `SW_FREQ_KHZ / 2) / `SW_FREQ_KHZ)

// Soft-start: full-scale ramp time spread over the 64 codes, least step
`define SS_TIME_US 340
`define SS_STEP_CYCLES ((`SS_TIME_US * 1000000 + 64 * `CLK_PS - 1) / (64 * `CLK_PS))

// One 12.5 mV code at 80 mV/us; each slew code doubles it
`define SLEW_STEP_PS 156250

// Current-limit shutdown
`define CL_RUN_LIMIT 16
`define RETRY_TIME_US 1700
`define RETRY_CYCLES (`RETRY_TIME_US * 1000000 / `CLK_PS)

`endif

// [tb/buck_ctrl_checker.sv]
/*
  Port-level checker for the regulator control core.
  Assumes one clock domain and synchronous active-high reset.
*/
`timescale 1ns/1ns
module buck_chk (
  input wire CLK_I,
  input wire RESET_I,
  input wire HW_ENABLE_I,
  input wire RD_I,
  input wire [7:0] RDATA_O,
  input wire [5:0] REF_CODE_O,
  input wire SWITCH_EN_O,
  input wire SYNC_RECT_EN_O,
  input wire TRISTATE_O,
  input wire DISCHARGE_O,
  input wire FORCE_PWM_O,
  input wire PFM_O,
  input wire SW_TICK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // Pin low long enough to pass the synchronizer
  a_off_no_switch: assert property (!HW_ENABLE_I [*4] |-> !SWITCH_EN_O)
    else $error("switching with enable pin low");
  // Bleed needs one cycle more: the control bit returns to its default first
  a_off_bleed: assert property (!HW_ENABLE_I [*5] |-> DISCHARGE_O)
    else $error("no discharge with enable pin low");
  a_tri_inverse: assert property (TRISTATE_O != SWITCH_EN_O)
    else $error("tristate not inverse of switching");
  a_sync_switch: assert property (SYNC_RECT_EN_O |-> SWITCH_EN_O)
    else $error("rectifier on without switching");
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside answer cycle");
  a_pfm_auto: assert property (PFM_O |-> !FORCE_PWM_O)
    else $error("pfm while pwm forced");
  // Upward moves go one code at a time
  a_ref_step: assert property ($past(SWITCH_EN_O) && REF_CODE_O > $past(REF_CODE_O)
    |-> REF_CODE_O == $past(REF_CODE_O) + 6'h01)
    else $error("reference jumped upward");
  a_tick_pulse: assert property (SW_TICK_O |=> !SW_TICK_O [*8])
    else $error("switching ticks too close");
  c_tick: cover property (SW_TICK_O);
  c_pfm: cover property (PFM_O);
  c_pwm: cover property (FORCE_PWM_O);
endmodule
bind buck_ctrl buck_chk chk_i (.CLK_I, .RESET_I, .HW_ENABLE_I, .RD_I, .RDATA_O,
  .REF_CODE_O, .SWITCH_EN_O, .SYNC_RECT_EN_O, .TRISTATE_O, .DISCHARGE_O,
  .FORCE_PWM_O, .PFM_O, .SW_TICK_O);

// [tb/bus_host.sv]
/*
  Register host model: one-cycle write and read strobes.
  Assumes read data registered one cycle after the strobe.
*/
`timescale 1ns/1ns
module bus_host (
  input wire clk_i,
  input wire [7:0] rdata_i,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  // Strobes last one cycle; wdata after a write and addr after a read carry junk, not old values
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Data taken at the edge that closes the answer cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for the regulator control core.
  Assumes the host model in bus_host and shortened retry and soft-start.
*/
`timescale 1ns/1ns
module tb;
  logic clk_i = 0, rst_i = 1, en_i = 0, sel_i = 0, cl_i = 0, ll_i = 0, st_i = 0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, sw_en, sr_en, tri_o, dis, fpwm, pfm, tick;
  wire [5:0] ref_code;
  int n_errors = 0, n_checks = 0, t, s, c, m;
  logic [7:0] d;
  logic [7:0] regs [3];
  initial forever #10 clk_i = ~clk_i;
  // Short counts keep the run brief
  buck_ctrl #(.RETRY_CYCLES(200), .SS_STEP_CYCLES(4)) buck_ctrl_i (.CLK_I(clk_i),
    .RESET_I(rst_i), .HW_ENABLE_I(en_i), .VOLTAGE_SELECT_PIN_I(sel_i), .CUR_LIMIT_I(cl_i),
    .LIGHT_LOAD_I(ll_i), .OUT_SETTLED_I(st_i), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .REF_CODE_O(ref_code), .SWITCH_EN_O(sw_en),
    .SYNC_RECT_EN_O(sr_en), .TRISTATE_O(tri_o), .DISCHARGE_O(dis), .FORCE_PWM_O(fpwm),
    .PFM_O(pfm), .SW_TICK_O(tick));
  bus_host bus_host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  task report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Bounded wait on reference code or switching level; t counts cycles
  task wfor(input bit r, input logic [5:0] v);
    t = 0;
    while ((r ? ref_code : {5'h00, sw_en}) !== v) begin
      @(posedge clk_i);
      t++;
      if (t > 9000) begin
        n_errors++;
        report_and_stop;
      end
    end
  endtask
  // Model keeps the three writable registers
  task wreg(input logic [7:0] a, input logic [7:0] v);
    bus_host_i.wr(a, v);
    if (a < 3) regs[a] = v;
  endtask
  task rchk(input logic [7:0] a);
    bus_host_i.rd(a, d);
    chk("rdata", a < 3 ? regs[a] : 8'h00, d);
  endtask
  initial begin
    s = $urandom(32'heb07_c6ad);
    regs = '{8'h00, 8'ha0, 8'h80};
    cyc(16);
    rst_i <= 0;
    cyc(4);
    chk("sw_off", 0, sw_en);
    chk("bleed", 1, dis);
    bus_host_i.rd(8'h01, d);
    chk("rd_off", 0, d);
    en_i <= 1;
    cyc(4);
    for (int a = 0; a < 5; a++) rchk(a);
    chk("sw_low", 0, sw_en);
    chk("bleed_sw", 1, dis);
    sel_i <= 1;
    wfor(0, 1);
    chk("sr_soft", 0, sr_en);
    wfor(1, 6'h20);
    cyc(3);
    chk("sr_run", 1, sr_en);
    // Upward ramp at a random slew code, step interval measured
    s = $urandom_range(3);
    wreg(8'h02, s);
    c = 8'h22 + $urandom_range(20);
    m = (15625 * (1 << s) + 1999) / 2000;
    wreg(8'h01, 8'h80 | c);
    wfor(1, 6'h21);
    wfor(1, 6'h22);
    chk("slew", m, t);
    wfor(1, c);
    chk("ref", c, ref_code);
    ll_i <= 1;
    wreg(8'h01, 8'hc0 | c);
    cyc(4);
    chk("fpwm", 1, fpwm);
    chk("pfm_f", 0, pfm);
    wreg(8'h01, 8'h80 | c);
    cyc(4);
    chk("pfm", 1, pfm);
    // Tick spacing while running: one nominal switching cycle of 21 clocks
    for (int k = 0; k < 2; k++) begin
      t = 0;
      do begin
        @(posedge clk_i);
        t++;
      end while (!tick && t < 50);
    end
    chk("tick", 21, t);
    // Select pin moves to a lower code: coast until settled
    wreg(8'h00, 8'h90);
    sel_i <= 0;
    cyc(5);
    chk("coast", 0, sw_en);
    chk("ref_lo", 8'h10, ref_code);
    st_i <= 1;
    wfor(0, 1);
    cl_i <= 1;
    wfor(0, 0);
    chk("tri_flt", 1, tri_o);
    cl_i <= 0;
    chk("cl_run", 1, t >= 15 * 21 && t <= 17 * 21 + 4);
    wfor(0, 1);
    chk("retry", 1, t >= 200);
    // Pin low wipes the registers
    wreg(8'h02, 8'h03);
    en_i <= 0;
    cyc(5);
    chk("sw_pin", 0, sw_en);
    en_i <= 1;
    cyc(4);
    regs = '{8'h00, 8'ha0, 8'h80};
    rchk(2);
    rchk(0);
    report_and_stop;
  end
endmodule
